// *** hdl/astd_pkg.sv ***
// Constants, enumerations and carriers shared by the audio trigger decoder
// Assumes one link (bit clock, word select, data) and a free-running system clock
package astd_pkg;

   localparam int NCH = 8;
   localparam int WORD_W = 32;
   localparam int POS_W = 8;
   localparam int FLEN_W = 12;
   localparam int WIN_W = 16;
   localparam int TS_W = 48;
   localparam int FC_W = 32;
   localparam int SLOT_W = 4;
   localparam logic [SLOT_W-1:0] LR_SLOTS = 4'h2;
   localparam logic [SLOT_W-1:0] SLOT_MAX = 4'hf;
   localparam logic [POS_W-1:0] POS_MAX = 8'hff;
   localparam logic [FLEN_W-1:0] FLEN_MAX = 12'hfff;
   localparam logic [FLEN_W-1:0] FLEN_FIRST = 12'h001;
   localparam logic [WIN_W-1:0] WIN_MAX = 16'hffff;
   localparam logic [TS_W-1:0] TS_RST = 48'h0;
   localparam logic [FC_W-1:0] FC_RST = 32'h0;

   typedef enum logic [6:0] {
      cmp_disabled = 7'h01,
      cmp_equal = 7'h02,
      not_equal_compare = 7'h04,
      greater_compare = 7'h08,
      less_compare = 7'h10,
      inside_range_compare = 7'h20,
      outside_range_compare = 7'h40
   } astd_cmp_t;

   typedef enum logic [3:0] {
      data_match_type = 4'h1,
      window_type = 4'h2,
      word_select_edge_type = 4'h4,
      frame_length_error_type = 4'h8
   } astd_trig_t;

   typedef enum logic [3:0] {
      no_channel_state = 4'h1,
      frame_error_state = 4'h2,
      frame_ok_state = 4'h4,
      partial_capture_state = 4'h8
   } astd_state_t;

   typedef struct packed {
      astd_cmp_t cond;
      logic [WORD_W-1:0] range_low_value;
      logic [WORD_W-1:0] range_high_value;
   } astd_chan_cfg_t;

   // Channel 0 is left or TDM 1, channel 1 is right or TDM 2
   typedef struct packed {
      logic tdm_mode;
      logic ws_invert;
      logic sample_falling;
      logic [POS_W-1:0] word_len;
      logic [POS_W-1:0] chan_len;
      logic [POS_W-1:0] chan_offset;
      logic [SLOT_W-1:0] tdm_count;
      logic combine_or;
      astd_trig_t trig_type;
      logic word_select_edge_direction;
      logic [WIN_W-1:0] window_frame_count;
      astd_chan_cfg_t [NCH-1:0] chan;
   } astd_cfg_t;

   typedef struct packed {
      logic valid;
      astd_state_t frame_state;
      astd_state_t [NCH-1:0] chan_state;
      logic [NCH-1:0][WORD_W-1:0] value;
   } astd_lrpt_t;

   typedef struct packed {
      logic [TS_W-1:0] start_time;
      logic [TS_W-1:0] stop_time;
      astd_lrpt_t rpt;
   } astd_frame_t;

endpackage

// *** hdl/astd_sync.sv ***
// Two-flop synchroniser for levels, toggles and quasi-static words
// Assumes multi-bit inputs are static while read or change one bit at a time
`timescale 1ns/10ps
module astd_sync #(
   parameter int W = 1
) (
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic [W-1:0] i_d,
   output logic [W-1:0] o_q
);

   logic [W-1:0] meta_reg;
   logic [W-1:0] sync_reg;

   if (W < 1) begin : g_bad_width
      $error("astd_sync: width must be at least one");
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         meta_reg <= '0;
         sync_reg <= '0;
      end else begin
         meta_reg <= i_d;
         sync_reg <= meta_reg;
      end
   end

   assign o_q = sync_reg;

endmodule // astd_sync

// *** hdl/astd_trigger_decoder.sv ***
// Audio serial trigger and decoder: link-side framing and compare, system-side reporting
// Assumes config is quasi-static during acquisition and the bit clock runs while frames flow
`timescale 1ns/10ps
module astd_trigger_decoder (
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic i_bclk,
   input wire logic i_ws,
   input wire logic i_data,
   input wire logic i_acq_run,
   input wire astd_pkg::astd_cfg_t i_cfg,
   output logic o_trigger,
   output logic o_frame_valid,
   output astd_pkg::astd_frame_t o_frame,
   output logic [astd_pkg::FC_W-1:0] o_decoded_frame_count
);

   localparam int W = astd_pkg::WORD_W;
   localparam int N = astd_pkg::NCH;
   localparam int PW = astd_pkg::POS_W;
   localparam int SW = astd_pkg::SLOT_W;
   localparam int CFG_W = $bits(astd_pkg::astd_cfg_t);

   if (N != 8 || W < 2 || W > 255 || PW != 8) begin : g_bad_cfg
      $error("astd_trigger_decoder: unsupported package widths");
   end

   function automatic logic cmp_hit(input astd_pkg::astd_cmp_t c, input logic [W-1:0] v,
                                    input logic [W-1:0] lo, input logic [W-1:0] hi);
      logic r;
      r = 1'b0;
      unique case (c)
         astd_pkg::cmp_disabled: r = 1'b0;
         astd_pkg::cmp_equal: r = ($signed(v) == $signed(lo));
         astd_pkg::not_equal_compare: r = ($signed(v) != $signed(lo));
         astd_pkg::greater_compare: r = ($signed(v) > $signed(lo));
         astd_pkg::less_compare: r = ($signed(v) < $signed(lo));
         astd_pkg::inside_range_compare: r = ($signed(v) >= $signed(lo)) && ($signed(v) <= $signed(hi));
         astd_pkg::outside_range_compare: r = ($signed(v) < $signed(lo)) || ($signed(v) > $signed(hi));
         default: r = 1'b0;
      endcase
      return r;
   endfunction

   // Link-domain reset, config and run level
   logic lrst_b;
   logic lrun;
   logic [CFG_W-1:0] lcfg_bits;
   astd_pkg::astd_cfg_t lcfg;

   astd_sync #(.W(1)) u_lrst_sync (
      .i_clk(i_bclk),
      .i_rst_b(1'b1),
      .i_d(i_rst_b),
      .o_q(lrst_b)
   );

   // Config is only safe to change while stopped
   astd_sync #(.W(CFG_W)) u_cfg_sync (
      .i_clk(i_bclk),
      .i_rst_b(lrst_b),
      .i_d(i_cfg),
      .o_q(lcfg_bits)
   );

   astd_sync #(.W(1)) u_run_sync (
      .i_clk(i_bclk),
      .i_rst_b(lrst_b),
      .i_d(i_acq_run),
      .o_q(lrun)
   );

   assign lcfg = astd_pkg::astd_cfg_t'(lcfg_bits);

   // Pin capture on both edges, one of them chosen
   logic pos_data_reg;
   logic pos_ws_reg;
   logic neg_data_reg;
   logic neg_ws_reg;
   logic smp_bit;
   logic smp_ws;

   always_ff @(posedge i_bclk) begin
      pos_data_reg <= i_data;
      pos_ws_reg <= i_ws;
   end

   always_ff @(negedge i_bclk) begin
      neg_data_reg <= i_data;
      neg_ws_reg <= i_ws;
   end

   assign smp_bit = lcfg.sample_falling ? neg_data_reg : pos_data_reg;
   assign smp_ws = lcfg.sample_falling ? neg_ws_reg : pos_ws_reg;

   // Link-domain state
   logic ws_prev_reg;
   logic run_prev_reg;
   logic active_reg;
   logic [PW-1:0] pos_reg;
   logic [SW-1:0] slot_reg;
   logic [W-1:0] shift_reg;
   logic [astd_pkg::FLEN_W-1:0] flen_reg;
   logic [astd_pkg::FLEN_W-1:0] flen_prev_reg;
   logic flen_known_reg;
   logic [astd_pkg::WIN_W-1:0] win_reg;
   logic err_pend_reg;
   logic trig_tgl_reg;
   logic bnd_tgl_reg;
   logic [N-1:0] done_reg;
   logic [N-1:0] met_reg;
   logic [N-1:0][W-1:0] vals_reg;
   astd_pkg::astd_lrpt_t rpt_reg;

   // Framing decode
   logic start_lvl;
   logic ws_edge;
   logic frame_start;
   logic frame_end;
   logic stop_cut;
   logic [SW-1:0] lr_slot;
   logic [SW-1:0] nslots;
   logic [PW-1:0] wlen_eff;
   logic [PW:0] word_end;
   logic slot_wrap;
   logic active_next;
   logic [PW-1:0] pos_next;
   logic [SW-1:0] slot_next;
   logic in_word;
   logic word_last;
   logic [W-1:0] shift_next;
   logic [PW-1:0] sh_amt;
   logic [W-1:0] word_shl;
   logic [W-1:0] word_val;
   logic word_hit;
   astd_pkg::astd_chan_cfg_t cur_cfg;

   // Frames are delimited by word-select edges from the transmitter, or cut short when the run stops
   assign start_lvl = lcfg.tdm_mode ? ~lcfg.ws_invert : lcfg.ws_invert;
   assign ws_edge = (smp_ws != ws_prev_reg);
   assign frame_start = ws_edge && (smp_ws == start_lvl) && lrun;
   assign frame_end = frame_start && active_reg;
   assign stop_cut = run_prev_reg && !lrun && active_reg;
   assign lr_slot = {3'h0, smp_ws != lcfg.ws_invert};
   assign nslots = lcfg.tdm_mode ? lcfg.tdm_count : astd_pkg::LR_SLOTS;
   assign wlen_eff = (lcfg.word_len == '0) ? PW'(1) :
                     (lcfg.word_len > PW'(W)) ? PW'(W) : lcfg.word_len;
   assign word_end = {1'b0, lcfg.chan_offset} + {1'b0, wlen_eff};
   assign slot_wrap = lcfg.tdm_mode && (pos_reg == PW'(lcfg.chan_len - 1'b1));
   assign active_next = frame_start || (lrun && active_reg);

   always_comb begin
      pos_next = (pos_reg == astd_pkg::POS_MAX) ? pos_reg : PW'(pos_reg + 1'b1);
      slot_next = slot_reg;
      if (frame_start) begin
         pos_next = '0;
         slot_next = lcfg.tdm_mode ? '0 : lr_slot;
      end else if (!lcfg.tdm_mode && ws_edge) begin
         pos_next = '0;
         slot_next = lr_slot;
      end else if (slot_wrap) begin
         pos_next = '0;
         slot_next = (slot_reg == astd_pkg::SLOT_MAX) ? slot_reg : SW'(slot_reg + 1'b1);
      end
   end

   // Word capture, MSB first, after the channel offset
   assign in_word = active_next && (slot_next < nslots) && ({1'b0, pos_next} >= {1'b0, lcfg.chan_offset}) &&
                    ({1'b0, pos_next} < word_end);
   assign word_last = in_word && ({1'b0, pos_next} == (word_end - 9'h001));
   assign shift_next = in_word ? {shift_reg[W-2:0], smp_bit} : shift_reg;
   assign sh_amt = PW'(W) - wlen_eff;
   assign word_shl = shift_next << sh_amt;
   assign word_val = W'($signed(word_shl) >>> sh_amt);
   assign cur_cfg = lcfg.chan[slot_next[2:0]];
   assign word_hit = cmp_hit(cur_cfg.cond, word_val, cur_cfg.range_low_value, cur_cfg.range_high_value);

   // Frame combine on registered per-channel results
   logic [N-1:0] present;
   logic [N-1:0] en;
   logic all_ok;
   logic any_ok;
   logic data_hit;
   logic len_err;
   logic [astd_pkg::WIN_W-1:0] win_next;
   logic fire_data;
   logic fire_win;
   logic fire_ws;
   logic fire_err;
   logic fire;

   for (genvar i = 0; i < N; i++) begin : g_chan
      assign present[i] = (SW'(i) < nslots);
      assign en[i] = present[i] && (lcfg.chan[i].cond != astd_pkg::cmp_disabled);
   end

   assign all_ok = &(~en | (met_reg & done_reg));
   assign any_ok = |(en & met_reg & done_reg);
   assign data_hit = lcfg.combine_or ? any_ok : ((|en) && all_ok);
   assign len_err = flen_known_reg && (flen_reg != flen_prev_reg);

   always_comb begin
      win_next = win_reg;
      if (!lrun) begin
         win_next = '0;
      end else if (frame_end) begin
         if (!data_hit) begin
            win_next = '0;
         end else if (win_reg != astd_pkg::WIN_MAX) begin
            win_next = astd_pkg::WIN_W'(win_reg + 1'b1);
         end
      end
   end

   // Combining only reaches the data and window types
   assign fire_data = (lcfg.trig_type == astd_pkg::data_match_type) && frame_end && data_hit;
   assign fire_win = (lcfg.trig_type == astd_pkg::window_type) && frame_end && data_hit &&
                     (win_next == lcfg.window_frame_count);
   assign fire_ws = (lcfg.trig_type == astd_pkg::word_select_edge_type) && lrun && ws_edge &&
                    (smp_ws != lcfg.word_select_edge_direction);
   assign fire_err = (lcfg.trig_type == astd_pkg::frame_length_error_type) && err_pend_reg;
   assign fire = fire_data || fire_win || fire_ws || fire_err;

   // Report of the frame just closed
   astd_pkg::astd_lrpt_t rpt_next;

   always_comb begin
      rpt_next.valid = frame_end || stop_cut;
      rpt_next.value = vals_reg;
      for (int i = 0; i < N; i++) begin
         if (!present[i]) begin
            rpt_next.chan_state[i] = astd_pkg::no_channel_state;
         end else if (stop_cut) begin
            rpt_next.chan_state[i] = astd_pkg::partial_capture_state;
         end else if (len_err || !done_reg[i]) begin
            rpt_next.chan_state[i] = astd_pkg::frame_error_state;
         end else begin
            rpt_next.chan_state[i] = astd_pkg::frame_ok_state;
         end
      end
      if (stop_cut) begin
         rpt_next.frame_state = astd_pkg::partial_capture_state;
      end else if (len_err || |(present & ~done_reg)) begin
         rpt_next.frame_state = astd_pkg::frame_error_state;
      end else begin
         rpt_next.frame_state = astd_pkg::frame_ok_state;
      end
   end

   always_ff @(posedge i_bclk) begin
      if (!lrst_b) begin
         ws_prev_reg <= 1'b0;
         run_prev_reg <= 1'b0;
         active_reg <= 1'b0;
         pos_reg <= '0;
         slot_reg <= '0;
         shift_reg <= '0;
         win_reg <= '0;
         err_pend_reg <= 1'b0;
         trig_tgl_reg <= 1'b0;
      end else begin
         ws_prev_reg <= smp_ws;
         run_prev_reg <= lrun;
         active_reg <= active_next;
         pos_reg <= pos_next;
         slot_reg <= slot_next;
         shift_reg <= shift_next;
         win_reg <= win_next;
         err_pend_reg <= frame_end && len_err;
         if (fire) begin
            trig_tgl_reg <= ~trig_tgl_reg;
         end
      end
   end

   // Frame length in sampled bit clocks
   always_ff @(posedge i_bclk) begin
      if (!lrst_b) begin
         flen_reg <= '0;
         flen_prev_reg <= '0;
         flen_known_reg <= 1'b0;
      end else begin
         if (frame_start) begin
            flen_reg <= astd_pkg::FLEN_FIRST;
            flen_prev_reg <= flen_reg;
            flen_known_reg <= active_reg;
         end else begin
            flen_reg <= (flen_reg == astd_pkg::FLEN_MAX) ? flen_reg : astd_pkg::FLEN_W'(flen_reg + 1'b1);
            if (!lrun) begin
               flen_known_reg <= 1'b0;
            end
         end
      end
   end

   // A word ending on a frame start belongs to the new frame, so set beats clear
   always_ff @(posedge i_bclk) begin
      if (!lrst_b) begin
         done_reg <= '0;
         met_reg <= '0;
         vals_reg <= '0;
      end else begin
         if (frame_start || !lrun) begin
            done_reg <= '0;
            met_reg <= '0;
         end
         if (word_last) begin
            done_reg[slot_next[2:0]] <= 1'b1;
            met_reg[slot_next[2:0]] <= word_hit;
            vals_reg[slot_next[2:0]] <= word_val;
         end
      end
   end

   // Report held until the next boundary, long enough for the system side
   always_ff @(posedge i_bclk) begin
      if (!lrst_b) begin
         bnd_tgl_reg <= 1'b0;
         rpt_reg <= '0;
      end else if (frame_start || stop_cut) begin
         bnd_tgl_reg <= ~bnd_tgl_reg;
         rpt_reg <= rpt_next;
      end
   end

   // System domain: events, timestamps, frame count
   logic [1:0] tgl_sync;
   logic [1:0] tgl_prev_reg;
   logic trig_evt;
   logic bnd_evt;
   logic run_rise;
   logic run_prev_sys_reg;
   logic trigger_reg;
   logic frame_valid_reg;
   logic [astd_pkg::TS_W-1:0] ts_reg;
   logic [astd_pkg::TS_W-1:0] stamp_reg;
   logic [astd_pkg::FC_W-1:0] decoded_frame_count_reg;
   astd_pkg::astd_frame_t frame_reg;

   astd_sync #(.W(2)) u_tgl_sync (
      .i_clk(i_clk),
      .i_rst_b(i_rst_b),
      .i_d({trig_tgl_reg, bnd_tgl_reg}),
      .o_q(tgl_sync)
   );

   assign trig_evt = tgl_sync[1] ^ tgl_prev_reg[1];
   assign bnd_evt = tgl_sync[0] ^ tgl_prev_reg[0];
   assign run_rise = i_acq_run && !run_prev_sys_reg;

   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         tgl_prev_reg <= '0;
         run_prev_sys_reg <= 1'b0;
         trigger_reg <= 1'b0;
         frame_valid_reg <= 1'b0;
         ts_reg <= astd_pkg::TS_RST;
         stamp_reg <= astd_pkg::TS_RST;
      end else begin
         tgl_prev_reg <= tgl_sync;
         run_prev_sys_reg <= i_acq_run;
         trigger_reg <= trig_evt && i_acq_run;
         frame_valid_reg <= bnd_evt && rpt_reg.valid;
         ts_reg <= astd_pkg::TS_W'(ts_reg + 1'b1);
         if (bnd_evt) begin
            stamp_reg <= ts_reg;
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         frame_reg <= '0;
         decoded_frame_count_reg <= astd_pkg::FC_RST;
      end else begin
         if (bnd_evt && rpt_reg.valid) begin
            frame_reg <= '{start_time: stamp_reg, stop_time: ts_reg, rpt: rpt_reg};
         end
         if (run_rise) begin
            decoded_frame_count_reg <= astd_pkg::FC_RST;
         end else if (bnd_evt && rpt_reg.valid) begin
            decoded_frame_count_reg <= astd_pkg::FC_W'(decoded_frame_count_reg + 1'b1);
         end
      end
   end

   assign o_trigger = trigger_reg;
   assign o_frame_valid = frame_valid_reg;
   assign o_frame = frame_reg;
   assign o_decoded_frame_count = decoded_frame_count_reg;

endmodule // astd_trigger_decoder

// *** testbench/astd_i2s_tx.sv ***
// Behavioural serial audio transmitter: two slots a frame, word after one lead bit
// Assumes words change only between slots; makes its own 30 ns bit clock
`timescale 1ns/10ps
module astd_i2s_tx #(
   parameter int SLOT = 16
) (
   input wire logic [7:0] i_left,
   input wire logic [7:0] i_right,
   input wire logic [3:0] i_extra,
   output logic o_bclk,
   output logic o_ws,
   output logic o_data
);
   int pos = 0;
   logic [7:0] word = 8'h00;
   logic [3:0] extra = 4'h0;
   initial begin
      o_bclk = 1'b0;
      o_ws = 1'b1;
      o_data = 1'b0;
      #7;
      forever #15 o_bclk = ~o_bclk;
   end
   // Falling-edge launch so the rising-edge sampler sees settled levels
   always @(negedge o_bclk) begin
      if (pos >= SLOT - 1 + (o_ws ? int'(extra) : 0)) begin
         pos = 0;
         o_ws = ~o_ws;
         if (!o_ws) begin
            extra = i_extra;
         end
         word = o_ws ? i_right : i_left;
      end else begin
         pos = pos + 1;
      end
      // Padding toggles so no stale bit looks like data
      o_data = (pos >= 1 && pos <= 8) ? word[8 - pos] : pos[0];
   end
endmodule // astd_i2s_tx

// *** testbench/astd_trigger_decoder_assertions.sv ***
// Port-level checks of the audio trigger decoder
// Assumes the bench binds it to the decoder top and drives a 100 MHz system clock
`timescale 1ns/10ps
module astd_trigger_decoder_assertions (
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic i_bclk,
   input wire logic i_ws,
   input wire logic i_data,
   input wire logic i_acq_run,
   input wire astd_pkg::astd_cfg_t i_cfg,
   input wire logic o_trigger,
   input wire logic o_frame_valid,
   input wire astd_pkg::astd_frame_t o_frame,
   input wire logic [astd_pkg::FC_W-1:0] o_decoded_frame_count
);
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_rst_b);
   // Long quiet run-low spell; starts after the cut-frame report that follows the fall
   logic [4:0] idle_reg;
   always_ff @(posedge i_clk) begin
      if (!i_rst_b || i_acq_run) begin
         idle_reg <= 5'h00;
      end else if (idle_reg != 5'h1f) begin
         idle_reg <= idle_reg + 5'h01;
      end
   end
   sequence s_one_cycle(logic sig);
      sig ##1 !sig;
   endsequence
   a_trig_pulse: assert property (o_trigger |-> s_one_cycle(o_trigger))
      else $error("trigger longer than one cycle");
   a_report_pulse: assert property (o_frame_valid |-> s_one_cycle(o_frame_valid))
      else $error("frame report longer than one cycle");
   a_count_step: assert property ($changed(o_decoded_frame_count) && o_decoded_frame_count != 32'h0 |->
      o_frame_valid && o_decoded_frame_count == $past(o_decoded_frame_count) + 32'h1)
      else $error("frame count moved without a single report");
   a_count_nonzero: assert property (o_frame_valid |-> o_decoded_frame_count != 32'h0)
      else $error("frame count zero at report");
   a_count_clear: assert property ($rose(i_acq_run) |-> ##[1:8] o_decoded_frame_count == 32'h0)
      else $error("frame count not cleared at run start");
   a_frame_hold: assert property (!o_frame_valid |-> $stable(o_frame))
      else $error("frame record changed without report");
   a_time_order: assert property (o_frame_valid |-> o_frame.stop_time > o_frame.start_time)
      else $error("frame stop not after start");
   a_ok_states: assert property (o_frame_valid && !i_cfg.tdm_mode &&
      o_frame.rpt.frame_state == astd_pkg::frame_ok_state |->
      o_frame.rpt.chan_state[0] == astd_pkg::frame_ok_state && o_frame.rpt.chan_state[1] == astd_pkg::frame_ok_state)
      else $error("ok frame with a channel not ok");
   a_left_sext: assert property (o_frame_valid && i_cfg.word_len == 8'h08 &&
      o_frame.rpt.chan_state[0] == astd_pkg::frame_ok_state |->
      (&o_frame.rpt.value[0][31:7]) || !(|o_frame.rpt.value[0][31:7]))
      else $error("left word not sign extended");
   a_idle_quiet: assert property (idle_reg == 5'h1f |-> !o_trigger && !o_frame_valid)
      else $error("activity while acquisition stopped");
endmodule // astd_trigger_decoder_assertions

// *** testbench/astd_trigger_decoder_bench.sv ***
// Self-checking bench of the audio trigger decoder, one task per scenario
// Assumes the transmitter model and checker are compiled first
`timescale 1ns/10ps
module astd_trigger_decoder_bench;
   logic i_clk = 1'b0;
   logic i_rst_b = 1'b0;
   logic i_acq_run = 1'b0;
   logic bclk, ws, sdata, trig, fval;
   logic [7:0] left = 8'hfd;
   logic [7:0] right = 8'h05;
   logic [3:0] extra = 4'h0;
   astd_pkg::astd_cfg_t cfg;
   astd_pkg::astd_frame_t frame;
   logic [astd_pkg::FC_W-1:0] decoded_frame_count;
   int n_errors = 0, n_tests = 0, cyc = 0, n_trig = 0, n_val = 0, t_trig = 0, t_val = 0, t0 = 0, v0 = 0;
   always #5 i_clk = ~i_clk;
   astd_i2s_tx astd_i2s_tx_i (.i_left(left), .i_right(right), .i_extra(extra), .o_bclk(bclk), .o_ws(ws),
      .o_data(sdata));
   astd_trigger_decoder astd_trigger_decoder_i (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_bclk(bclk), .i_ws(ws),
      .i_data(sdata), .i_acq_run(i_acq_run), .i_cfg(cfg), .o_trigger(trig), .o_frame_valid(fval),
      .o_frame(frame), .o_decoded_frame_count(decoded_frame_count));
   always @(posedge i_clk) begin
      cyc <= cyc + 1;
      if (trig === 1'b1) begin
         n_trig <= n_trig + 1;
         t_trig <= cyc;
      end
      if (fval === 1'b1) begin
         n_val <= n_val + 1;
         t_val <= cyc;
      end
      if (cyc == 40000) begin
         n_errors = n_errors + 1;
         close_out();
      end
   end
   task automatic close_out();
      $display("checks %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask
   task automatic chk(input string nm, input logic [47:0] exp, input logic [47:0] got);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // Config only moves while stopped, then settles through the sync stages
   task automatic start();
      tick(8);
      t0 = n_trig;
      v0 = n_val;
      i_acq_run = 1'b1;
   endtask
   task automatic wait_v(input int k);
      int lim;
      lim = 0;
      while (n_val - v0 < k && lim < 2000) begin
         tick(1);
         lim++;
      end
      // A stalled report stream counts against the run
      if (lim >= 2000) begin
         n_errors++;
         $display("wrong value report wait expected %0d seen %0d", k, n_val - v0);
      end
   endtask
   task automatic stop(input int n, input int lo, input int hi);
      tick(6);
      chk("triggers", 48'h1, 48'((n_trig - t0 >= lo) && (n_trig - t0 <= hi)));
      chk("frame count", 48'(n), 48'(decoded_frame_count));
      i_acq_run = 1'b0;
      tick(40);
      chk("cut state", 48'(astd_pkg::partial_capture_state), 48'(frame.rpt.frame_state));
   endtask
   task automatic t_compare();
      astd_pkg::astd_cmp_t ops [7] = '{astd_pkg::cmp_disabled, astd_pkg::cmp_equal, astd_pkg::not_equal_compare,
         astd_pkg::greater_compare, astd_pkg::less_compare, astd_pkg::inside_range_compare,
         astd_pkg::outside_range_compare};
      logic [6:0] hit = 7'h2c;
      cfg.chan[0].range_low_value = 32'hffff_fffb;
      cfg.chan[0].range_high_value = 32'h0000_0002;
      for (int i = 0; i < 7; i++) begin
         cfg.chan[0].cond = ops[i];
         start();
         wait_v(3);
         chk("left word", 48'hffff_fffd, 48'(frame.rpt.value[0]));
         chk("right word", 48'h5, 48'(frame.rpt.value[1]));
         chk("frame state", 48'(astd_pkg::frame_ok_state), 48'(frame.rpt.frame_state));
         stop(3, hit[i] ? 3 : 0, hit[i] ? 3 : 0);
      end
   endtask
   task automatic t_combine();
      cfg.chan[0].cond = astd_pkg::cmp_equal;
      cfg.chan[0].range_low_value = 32'hffff_fffd;
      cfg.chan[1].cond = astd_pkg::cmp_equal;
      cfg.chan[1].range_low_value = 32'h0000_0007;
      for (int j = 0; j < 2; j++) begin
         cfg.combine_or = j[0];
         start();
         wait_v(3);
         stop(3, 3 * j, 3 * j);
      end
   endtask
   task automatic t_window();
      int wl [3] = '{1, 3, 3};
      int nf [3] = '{3, 2, 6};
      cfg.trig_type = astd_pkg::window_type;
      cfg.chan[1].cond = astd_pkg::cmp_disabled;
      cfg.combine_or = 1'b0;
      for (int j = 0; j < 3; j++) begin
         cfg.window_frame_count = 16'(wl[j]);
         start();
         wait_v(nf[j]);
         stop(nf[j], 1 - (j % 2), 1 - (j % 2));
      end
      // A miss in the middle must restart the run of matches
      start();
      wait_v(1);
      left = 8'h10;
      wait_v(2);
      left = 8'hfd;
      wait_v(5);
      stop(5, 0, 0);
   endtask
   task automatic t_ws();
      cfg.trig_type = astd_pkg::word_select_edge_type;
      cfg.combine_or = 1'b1;
      for (int j = 0; j < 2; j++) begin
         cfg.word_select_edge_direction = j[0];
         start();
         wait_v(3);
         tick(6);
         chk("edge gap", 48'(j), 48'((t_val - t_trig < 20) && (t_trig - t_val < 20)));
         stop(3, 3, 4);
      end
   endtask
   task automatic t_error();
      cfg.trig_type = astd_pkg::frame_length_error_type;
      start();
      wait_v(2);
      extra = 4'h2;
      wait_v(3);
      extra = 4'h0;
      wait_v(5);
      stop(5, 2, 2);
   endtask
   // Inverted select: the high slot becomes left, frames start on the rise
   task automatic t_invert();
      cfg.trig_type = astd_pkg::data_match_type;
      cfg.ws_invert = 1'b1;
      cfg.combine_or = 1'b1;
      cfg.chan[0].cond = astd_pkg::cmp_equal;
      cfg.chan[0].range_low_value = 32'h0000_0005;
      cfg.chan[1].cond = astd_pkg::cmp_disabled;
      start();
      wait_v(3);
      chk("swapped left", 48'h5, 48'(frame.rpt.value[0]));
      chk("swapped right", 48'hffff_fffd, 48'(frame.rpt.value[1]));
      stop(3, 3, 3);
      cfg.ws_invert = 1'b0;
   endtask
   initial begin
      cfg = '0;
      cfg.word_len = 8'h08;
      cfg.chan_len = 8'h10;
      cfg.chan_offset = 8'h01;
      cfg.tdm_count = 4'h2;
      cfg.trig_type = astd_pkg::data_match_type;
      for (int k = 0; k < 8; k++) cfg.chan[k].cond = astd_pkg::cmp_disabled;
      // Long reset so the link side sees enough bit clocks
      tick(14);
      i_rst_b = 1'b1;
      tick(4);
      t_compare();
      t_combine();
      t_window();
      t_ws();
      t_error();
      t_invert();
      close_out();
   end
endmodule // astd_trigger_decoder_bench
bind astd_trigger_decoder astd_trigger_decoder_assertions astd_trigger_decoder_assertions_i (.i_clk(i_clk),
   .i_rst_b(i_rst_b), .i_bclk(i_bclk), .i_ws(i_ws), .i_data(i_data), .i_acq_run(i_acq_run), .i_cfg(i_cfg),
   .o_trigger(o_trigger), .o_frame_valid(o_frame_valid), .o_frame(o_frame),
   .o_decoded_frame_count(o_decoded_frame_count));
